/* rtl/cplg_pkg.sv */
// shared constants for the counter preset, latch and gate block
package cplg_pkg;
  localparam int         CPLG_CNT_W    = 32;
  localparam int         CPLG_SYNC_LEN = 2;
  localparam logic [1:0] CPLG_GATE_OFF = 2'h0;
  localparam logic [1:0] CPLG_GATE_HI  = 2'h1;
  localparam logic [1:0] CPLG_GATE_LO  = 2'h2;
  localparam logic       CPLG_POL_FALL = 1'h0;
  localparam logic       CPLG_POL_RISE = 1'h1;
  localparam logic       CPLG_BIT_CLR  = 1'h0;
  localparam logic       CPLG_BIT_SET  = 1'h1;

  typedef enum logic [2:0] {
    PS_IDLE,
    PS_SW,
    PS_RISE,
    PS_FALL,
    PS_DONE
  } cplg_preset_e;

  typedef enum logic [1:0] {
    CS_IDLE,
    CS_ARMED,
    CS_DONE
  } cplg_capture_e;
endpackage

/* rtl/cplg_edge_sync.sv */
// input synchroniser with rise and fall pulse detection
`timescale 1ns/1ns
module cplg_edge_sync
  import cplg_pkg::*;
#(
  parameter int SYNC_LEN = CPLG_SYNC_LEN
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [SYNC_LEN-1:0] sync_reg;
  logic                prev_reg;

  if (SYNC_LEN < 2) begin : g_bad_len
    $error("cplg_edge_sync: SYNC_LEN below two");
  end

  // first stage feeds only the next stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[SYNC_LEN-2:0], din};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= CPLG_BIT_CLR;
    end else begin
      prev_reg <= sync_reg[SYNC_LEN-1];
    end
  end

  assign level = sync_reg[SYNC_LEN-1];
  assign rise  = sync_reg[SYNC_LEN-1] & ~prev_reg;
  assign fall  = ~sync_reg[SYNC_LEN-1] & prev_reg;
endmodule

/* rtl/cplg_hold_reg.sv */
// loadable holding register for the captured counter value
`timescale 1ns/1ns
module cplg_hold_reg #(
  parameter int WIDTH = 32
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  if (WIDTH < 1) begin : g_bad_width
    $error("cplg_hold_reg: WIDTH below one");
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else if (load) begin
      q <= d;
    end
  end
endmodule

/* rtl/cplg_counter_preset_latch_gate.sv */
// counter with preset load, edge capture and gate lock control
`timescale 1ns/1ns
module cplg_counter_preset_latch_gate
  import cplg_pkg::*;
#(
  parameter int CNT_W = CPLG_CNT_W
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             gate_latch_in,
  input  wire logic             count_up,
  input  wire logic             count_down,
  input  wire logic [CNT_W-1:0] preset_value,
  input  wire logic             sw_preset_cmd,
  input  wire logic             preset_rise_arm,
  input  wire logic             preset_fall_arm,
  input  wire logic             capture_rise_arm,
  input  wire logic             capture_fall_arm,
  input  wire logic             continuous_capture_en,
  input  wire logic             ext_reset_en,
  input  wire logic             ext_reset_polarity,
  input  wire logic [1:0]       gate_polarity,
  input  wire logic             sw_gate_cmd,
  output logic      [CNT_W-1:0] counter_value_reg,
  output logic      [CNT_W-1:0] latch_value_reg,
  output logic                  capture_valid_reg,
  output logic                  preset_done_reg,
  output logic                  sw_gate_valid_reg,
  output logic                  counter_locked_reg,
  output logic                  capture_input_level_reg
);
  cplg_preset_e  ps_reg;
  cplg_preset_e  ps_next;
  cplg_capture_e cs_reg;
  cplg_capture_e cs_next;
  logic [1:0]    cap_mask_reg;
  logic          lvl;
  logic          rise;
  logic          fall;
  logic          gate_lock;
  logic          preset_fire;
  logic          reset_fire;
  logic          capture_fire;
  logic          any_preset_arm;
  logic          any_capture_arm;
  logic [CNT_W-1:0] counter_value_next;

  if (CNT_W < 2) begin : g_bad_width
    $error("cplg_counter_preset_latch_gate: CNT_W below two");
  end

  // gate lock decode, shared by counter and assertions
  function automatic logic lock_of(input logic [1:0] pol,
                                   input logic       level,
                                   input logic       sw);
    lock_of = sw | (pol == CPLG_GATE_HI && level)
                 | (pol == CPLG_GATE_LO && !level);
  endfunction

  cplg_edge_sync u_edge (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (gate_latch_in),
    .level  (lvl),
    .rise   (rise),
    .fall   (fall)
  );

  assign any_preset_arm  = sw_preset_cmd | preset_rise_arm | preset_fall_arm;
  assign any_capture_arm = capture_rise_arm | capture_fall_arm;
  assign gate_lock = lock_of(gate_polarity, lvl, sw_gate_cmd);

  // edge preset fires in the edge cycle even if the lock engages
  assign preset_fire = (ps_reg == PS_SW)
                     | (ps_reg == PS_RISE && rise)
                     | (ps_reg == PS_FALL && fall);
  assign reset_fire = ext_reset_en &&
                      ((ext_reset_polarity == CPLG_POL_RISE) ? rise
                                                             : fall);
  // either armed polarity, as latched when the capture armed
  // one-shot needs valid low even if continuous just went off
  assign capture_fire = (cs_reg == CS_ARMED) &&
                        (continuous_capture_en || !capture_valid_reg) &&
                        ((cap_mask_reg[1] && rise) ||
                         (cap_mask_reg[0] && fall));

  // preset arbiter: the first arm seen owns it, later ones are not served until the state returns to idle
  always_comb begin
    ps_next = ps_reg;
    unique case (ps_reg)
      PS_IDLE: begin
        if (sw_preset_cmd) begin
          ps_next = PS_SW;
        end else if (preset_rise_arm) begin
          ps_next = PS_RISE;
        end else if (preset_fall_arm) begin
          ps_next = PS_FALL;
        end
      end
      PS_SW: begin
        ps_next = PS_DONE;
      end
      PS_RISE: begin
        if (rise) begin
          ps_next = PS_DONE;
        end else if (!preset_rise_arm) begin
          ps_next = PS_IDLE;
        end
      end
      PS_FALL: begin
        if (fall) begin
          ps_next = PS_DONE;
        end else if (!preset_fall_arm) begin
          ps_next = PS_IDLE;
        end
      end
      PS_DONE: begin
        if (!any_preset_arm) begin
          ps_next = PS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ps_reg <= PS_IDLE;
    end else begin
      ps_reg <= ps_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      preset_done_reg <= CPLG_BIT_CLR;
    end else begin
      preset_done_reg <= (ps_next == PS_DONE);
    end
  end

  // capture arbiter; continuous mode stays armed
  always_comb begin
    cs_next = cs_reg;
    unique case (cs_reg)
      CS_IDLE: begin
        if (any_capture_arm) begin
          cs_next = CS_ARMED;
        end
      end
      CS_ARMED: begin
        if (!any_capture_arm) begin
          cs_next = capture_valid_reg ? CS_DONE : CS_IDLE;
        end else if (capture_fire && !continuous_capture_en) begin
          cs_next = CS_DONE;
        end
      end
      CS_DONE: begin
        if (!any_capture_arm) begin
          cs_next = CS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_reg <= CS_IDLE;
    end else begin
      cs_reg <= cs_next;
    end
  end

  // arms present at arming time; later arms are ignored
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cap_mask_reg <= '0;
    end else if (cs_reg == CS_IDLE) begin
      cap_mask_reg <= {capture_rise_arm, capture_fall_arm};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      capture_valid_reg <= CPLG_BIT_CLR;
    end else if (capture_fire) begin
      capture_valid_reg <= CPLG_BIT_SET;
    end else if (cs_next == CS_IDLE) begin
      capture_valid_reg <= CPLG_BIT_CLR;
    end
  end

  // captures the value before any load or lock of this edge
  cplg_hold_reg #(
    .WIDTH (CNT_W)
  ) u_latch (
    .clock  (clock),
    .arst_n (arst_n),
    .load   (capture_fire),
    .d      (counter_value_reg),
    .q      (latch_value_reg)
  );

  // load and clear override the lock, counting does not
  always_comb begin
    counter_value_next = counter_value_reg;
    if (preset_fire) begin
      counter_value_next = preset_value;
    end else if (reset_fire) begin
      counter_value_next = '0;
    end else if (!gate_lock && count_up && !count_down) begin
      counter_value_next = counter_value_reg + 1'b1;
    end else if (!gate_lock && count_down && !count_up) begin
      counter_value_next = counter_value_reg - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      counter_value_reg <= '0;
    end else begin
      counter_value_reg <= counter_value_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      counter_locked_reg <= CPLG_BIT_CLR;
      sw_gate_valid_reg  <= CPLG_BIT_CLR;
    end else begin
      counter_locked_reg <= gate_lock;
      sw_gate_valid_reg  <= sw_gate_cmd;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      capture_input_level_reg <= CPLG_BIT_CLR;
    end else begin
      capture_input_level_reg <= lvl;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_lock_holds;
    gate_lock && !preset_fire && !reset_fire |=> $stable(counter_value_reg);
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("locked counter changed");

  property p_reset_clears;
    reset_fire && !preset_fire |=> counter_value_reg == '0;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("edge reset did not clear counter");

  property p_preset_loads;
    preset_fire |=> counter_value_reg == $past(preset_value)
                    && preset_done_reg;
  endproperty
  a_preset_loads: assert property (p_preset_loads)
    else $error("preset not loaded or not acknowledged");

  property p_done_holds;
    preset_done_reg && any_preset_arm |=> preset_done_reg && !preset_fire;
  endproperty
  a_done_holds: assert property (p_done_holds)
    else $error("preset rearmed before arms cleared");

  property p_sw_preset;
    ps_reg == PS_IDLE && sw_preset_cmd |=> preset_fire ##1 preset_done_reg;
  endproperty
  a_sw_preset: assert property (p_sw_preset)
    else $error("software preset not served");

  property p_capture_value;
    capture_fire |=> latch_value_reg == $past(counter_value_reg)
                     && capture_valid_reg;
  endproperty
  a_capture_value: assert property (p_capture_value)
    else $error("capture did not store pre-edge value");

  property p_one_shot;
    (cs_reg == CS_DONE && any_capture_arm)
      || (capture_valid_reg && !continuous_capture_en)
      |=> $stable(latch_value_reg);
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot latch overwritten");

  property p_continuous;
    cs_reg == CS_ARMED && continuous_capture_en && any_capture_arm
      && capture_fire |=> cs_reg == CS_ARMED;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous capture disarmed");

  property p_level;
    ##1 capture_input_level_reg == $past(lvl);
  endproperty
  a_level: assert property (p_level)
    else $error("input level status wrong");

  property p_sw_gate;
    sw_gate_cmd |=> sw_gate_valid_reg && counter_locked_reg;
  endproperty
  a_sw_gate: assert property (p_sw_gate)
    else $error("software gate not shown");
endmodule

/* testbench/cplg_counter_preset_latch_gate_tb.sv */
// self-checking bench for the counter preset, latch and gate block
`timescale 1ns/1ns
module cplg_counter_preset_latch_gate_tb;
  import cplg_pkg::*;
  logic        clock;
  logic        arst_n;
  logic        gate_latch_in;
  logic        count_up;
  logic        count_down;
  logic [31:0] preset_value;
  logic        sw_preset_cmd;
  logic        preset_rise_arm;
  logic        preset_fall_arm;
  logic        capture_rise_arm;
  logic        capture_fall_arm;
  logic        continuous_capture_en;
  logic        ext_reset_en;
  logic        ext_reset_polarity;
  logic [1:0]  gate_polarity;
  logic        sw_gate_cmd;
  logic [31:0] counter_value_reg;
  logic [31:0] latch_value_reg;
  logic        capture_valid_reg;
  logic        preset_done_reg;
  logic        sw_gate_valid_reg;
  logic        counter_locked_reg;
  logic        capture_input_level_reg;
  int          n_fail;
  int          tests_run;
  int          cycles;
  logic [31:0] model;
  logic [31:0] pre;
  logic        lk;

  cplg_counter_preset_latch_gate #(.CNT_W(32)) i_dut (
    .clock                   (clock),
    .arst_n                  (arst_n),
    .gate_latch_in           (gate_latch_in),
    .count_up                (count_up),
    .count_down              (count_down),
    .preset_value            (preset_value),
    .sw_preset_cmd           (sw_preset_cmd),
    .preset_rise_arm         (preset_rise_arm),
    .preset_fall_arm         (preset_fall_arm),
    .capture_rise_arm        (capture_rise_arm),
    .capture_fall_arm        (capture_fall_arm),
    .continuous_capture_en   (continuous_capture_en),
    .ext_reset_en            (ext_reset_en),
    .ext_reset_polarity      (ext_reset_polarity),
    .gate_polarity           (gate_polarity),
    .sw_gate_cmd             (sw_gate_cmd),
    .counter_value_reg       (counter_value_reg),
    .latch_value_reg         (latch_value_reg),
    .capture_valid_reg       (capture_valid_reg),
    .preset_done_reg         (preset_done_reg),
    .sw_gate_valid_reg       (sw_gate_valid_reg),
    .counter_locked_reg      (counter_locked_reg),
    .capture_input_level_reg (capture_input_level_reg)
  );

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // generous ceiling, the whole sequence needs well under a thousand
  always @(posedge clock) begin
    cycles++;
    if (cycles > 5000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask

  // pulses held high count once per cycle; model skips them when locked
  task automatic count(input int n, input logic dn);
    count_up = ~dn;
    count_down = dn;
    tick(n);
    count_up = 1'h0;
    count_down = 1'h0;
    tick(1);
    if (!lk) model = dn ? model - n : model + n;
  endtask

  // two sync flops plus edge stage, four edges leaves margin
  task automatic pin(input logic v);
    gate_latch_in = v;
    tick(4);
    chk(capture_input_level_reg, v);
  endtask

  initial begin
    n_fail = 0; tests_run = 0; cycles = 0; model = 32'h0; lk = 1'h0;
    arst_n = 1'h0; gate_latch_in = 1'h0; count_up = 1'h0;
    count_down = 1'h0; preset_value = 32'h0; sw_preset_cmd = 1'h0;
    preset_rise_arm = 1'h0; preset_fall_arm = 1'h0;
    capture_rise_arm = 1'h0; capture_fall_arm = 1'h0;
    continuous_capture_en = 1'h0; ext_reset_en = 1'h0;
    ext_reset_polarity = 1'h0; gate_polarity = CPLG_GATE_OFF;
    sw_gate_cmd = 1'h0;
    repeat (10) @(posedge clock);
    #2 arst_n = 1'h1;
    tick(1);
    chk({counter_value_reg | latch_value_reg}, 32'h0);
    chk({capture_valid_reg, preset_done_reg, counter_locked_reg}, 32'h0);
    count(5, 1'h0);
    count(2, 1'h1);
    chk(counter_value_reg, model);
    // software preset, held command must not reload
    preset_value = 32'h1234ABCD;
    sw_preset_cmd = 1'h1;
    tick(3);
    model = preset_value;
    chk(counter_value_reg, model);
    chk(preset_done_reg, 1'h1);
    count(3, 1'h0);
    chk(counter_value_reg, model);
    // edge arm added while sw owns the preset is ignored
    preset_rise_arm = 1'h1;
    tick(2);
    pin(1'h1);
    chk(counter_value_reg, model);
    sw_preset_cmd = 1'h0;
    tick(2);
    chk(preset_done_reg, 1'h1);
    preset_rise_arm = 1'h0;
    tick(2);
    chk(preset_done_reg, 1'h0);
    pin(1'h0);
    // edge presets, rise then fall, each loading on its own armed edge
    for (int e = 0; e < 2; e++) begin
      preset_value = 32'hA0 + e;
      preset_rise_arm = (e == 0);
      preset_fall_arm = (e == 1);
      tick(2);
      count(4, 1'h0);
      pin(e == 0);
      model = preset_value;
      chk(counter_value_reg, model);
      chk(preset_done_reg, 1'h1);
      preset_rise_arm = 1'h0;
      preset_fall_arm = 1'h0;
      tick(2);
      chk(preset_done_reg, 1'h0);
    end
    // one-shot capture for rise, fall and both arms
    for (int m = 1; m < 4; m++) begin
      capture_rise_arm = m[0];
      capture_fall_arm = m[1];
      tick(2);
      count(3, 1'h0);
      pre = model;
      pin(~gate_latch_in);
      chk(latch_value_reg, pre);
      chk(capture_valid_reg, 1'h1);
      count(2, 1'h0);
      pin(~gate_latch_in);
      pin(~gate_latch_in);
      chk(latch_value_reg, pre);
      capture_rise_arm = 1'h0;
      capture_fall_arm = 1'h0;
      tick(2);
      chk(capture_valid_reg, 1'h0);
    end
    // continuous capture on every rising edge
    continuous_capture_en = 1'h1;
    capture_rise_arm = 1'h1;
    tick(2);
    pin(1'h0);
    for (int k = 0; k < 2; k++) begin
      count(k + 2, 1'h0);
      pin(1'h1);
      chk(latch_value_reg, model);
      pin(1'h0);
    end
    // continuous off with valid still set: next edge must not capture
    continuous_capture_en = 1'h0;
    pre = model;
    count(2, 1'h0);
    pin(1'h1);
    chk(latch_value_reg, pre);
    pin(1'h0);
    capture_rise_arm = 1'h0;
    continuous_capture_en = 1'h0;
    tick(2);
    // gate polarity table, code 3 treated as off
    for (int p = 0; p < 4; p++) begin
      for (int v = 0; v < 2; v++) begin
        gate_polarity = p[1:0];
        lk = (p == 1 && v == 1) || (p == 2 && v == 0);
        pin(v[0]);
        chk(counter_locked_reg, lk);
        count(2, 1'h0);
        chk(counter_value_reg, model);
      end
    end
    lk = 1'h1;
    sw_gate_cmd = 1'h1;
    tick(3);
    chk({sw_gate_valid_reg, counter_locked_reg}, 32'h3);
    count(3, 1'h0);
    chk(counter_value_reg, model);
    lk = 1'h0;
    sw_gate_cmd = 1'h0;
    tick(3);
    chk({sw_gate_valid_reg, counter_locked_reg}, 32'h0);
    gate_polarity = CPLG_GATE_OFF;
    pin(1'h0);
    // zero reset on the locking edge, rise then fall
    ext_reset_en = 1'h1;
    for (int r = 1; r >= 0; r--) begin
      gate_polarity = (r == 1) ? CPLG_GATE_HI : CPLG_GATE_LO;
      ext_reset_polarity = r[0];
      lk = 1'h0;
      tick(2);
      count(3, 1'h0);
      pin(r[0]);
      lk = 1'h1;
      model = 32'h0;
      chk(counter_value_reg, 32'h0);
      chk(counter_locked_reg, 1'h1);
      count(2, 1'h0);
      chk(counter_value_reg, 32'h0);
    end
    ext_reset_en = 1'h0;
    gate_polarity = CPLG_GATE_HI;
    lk = 1'h0;
    tick(2);
    // preset and capture on the locking edge
    preset_value = 32'hFFFF0001;
    preset_rise_arm = 1'h1;
    capture_rise_arm = 1'h1;
    tick(2);
    count(2, 1'h0);
    pre = model;
    pin(1'h1);
    lk = 1'h1;
    chk(latch_value_reg, pre);
    chk(counter_value_reg, 32'hFFFF0001);
    chk(counter_locked_reg, 1'h1);
    count(2, 1'h0);
    chk(counter_value_reg, 32'hFFFF0001);
    preset_rise_arm = 1'h0;
    capture_rise_arm = 1'h0;
    tick(2);
    chk({preset_done_reg, capture_valid_reg}, 32'h0);
    end_sim();
  end
endmodule
